// ==== verilog/sbd_defines.svh ====
// Purpose: encodings and cycle figures for the string/bit/transfer cost decoder
// Assumes: figures are core clocks and data bus cycles of the core
// Notes:   per-iteration figures are added once per iteration performed
`ifndef SBD_DEFINES_SVH
`define SBD_DEFINES_SVH
// lead bytes
`define SBD_PFX_REP    8'hF3
`define SBD_PFX_REPNE  8'hF2
`define SBD_ESC        8'h0F
// string opcodes, width bit dropped
`define SBD_OP_CMPS    7'h53
`define SBD_OP_INS     7'h36
`define SBD_OP_LODS    7'h56
`define SBD_OP_MOVS    7'h52
`define SBD_OP_OUTS    7'h37
`define SBD_OP_SCAS    7'h57
`define SBD_OP_STOS    7'h55
// bit opcodes after escape
`define SBD_OP_FSCAN   8'hBC
`define SBD_OP_RSCAN   8'hBD
`define SBD_OP_TGRP    8'hBA
`define SBD_OP_TST_R   8'hA3
`define SBD_OP_CLR_R   8'hB3
`define SBD_OP_SET_R   8'hAB
`define SBD_OP_CPL_R   8'hBB
`define SBD_FLD_TST    3'h4
`define SBD_FLD_SET    3'h5
`define SBD_FLD_CLR    3'h6
`define SBD_FLD_CPL    3'h7
// transfer opcodes and group fields
`define SBD_OP_CALLN   8'hE8
`define SBD_OP_CALLF   8'h9A
`define SBD_OP_GRP5    8'hFF
`define SBD_OP_JMPS    8'hEB
`define SBD_OP_JMPN    8'hE9
`define SBD_OP_JMPF    8'hEA
`define SBD_FLD_CALLN  3'h2
`define SBD_FLD_CALLF  3'h3
`define SBD_FLD_JMPN   3'h4
`define SBD_FLD_JMPF   3'h5
// clock figures
`define SBD_T_5        8'h05
`define SBD_T_7        8'h07
`define SBD_T_27       8'h1B
`define SBD_T_6        8'h06
`define SBD_T_26       8'h1A
`define SBD_T_10       8'h0A
`define SBD_T_3        8'h03
`define SBD_T_8        8'h08
`define SBD_T_12       8'h0C
`define SBD_T_13       8'h0D
`define SBD_T_9        8'h09
`define SBD_T_14       8'h0E
`define SBD_T_42       8'h2A
`define SBD_T_64       8'h40
`define SBD_T_98       8'h62
`define SBD_T_106      8'h6A
`define SBD_T_46       8'h2E
`define SBD_T_68       8'h44
`define SBD_T_102      8'h66
`define SBD_T_110      8'h6E
`define SBD_T_37       8'h25
`define SBD_T_53       8'h35
`define SBD_T_59       8'h3B
// per-unit figures
`define SBD_P_PARM_CLK 8'h08
`define SBD_P_PARM_DAT 8'h04
`endif

// ==== verilog/sbd_pkg.sv ====
// Purpose: types shared by the cost decoder and its bench
// Assumes: one core clock
// Notes:   request and result travel as packed structs
package sbd_pkg;
  typedef enum logic [1:0] {SBD_GRP_NONE, SBD_GRP_STRING, SBD_GRP_BIT,
                            SBD_GRP_XFER} sbd_group_type;
  typedef enum logic [1:0] {SBD_GATE_NONE, SBD_GATE_SAME,
                            SBD_GATE_DIFF} sbd_gate_type;
  typedef struct packed {
    logic [7:0]   lead;  // prefix, escape or transfer opcode
    logic [7:0]   op;    // byte after prefix or escape
    logic [2:0]   fld;   // reg field of the mod r/m byte
    logic         mem;   // operand in memory
    sbd_gate_type gate;  // far transfer through a gate
    logic [4:0]   parm;  // gate parameter count x
    logic [7:0]   comp;  // components at the target, m
    logic         slow;  // port string, long overhead form
  } sbd_req_type;
  typedef struct packed {
    logic          ok;
    sbd_group_type grp;
    logic          rep;
    logic          scan;
    logic          halt_eq;
    logic          bits;
    logic          per_x;
    logic          add_m;
    logic [7:0]    bclk;
    logic [3:0]    pclk;
    logic [7:0]    bdat;
    logic [3:0]    pdat;
  } sbd_cost_type;
  typedef struct packed {
    logic          ok;
    sbd_group_type grp;
    logic [31:0]   clocks;
    logic [31:0]   data;
  } sbd_res_type;
endpackage

// ==== verilog/sbd_cost_decoder.sv ====
// Purpose: decode string, bit and transfer opcodes and account their cost
// Assumes: request fields come from fetch logic on clk_i, no synchroniser
// Notes:   repeated strings run down the count, one iteration per clock
//
// Contract
// - f2 then compare opcode: 5 clocks plus 9 and 2 data per iteration
// - port input string: 7 or 27 plus 6 per iteration, 1 data each
// - load string: 5 plus 6 per iteration, 1 data each
// - move string: 7 plus 4 per iteration, 2 data each
// - port output string: 6 or 26 plus 5 per iteration, 1 data each
// - scan with f3 stops on mismatch, f2 on match; 5 plus 8 each
// - store string: 5 plus 5 per iteration, 1 data each
// - forward and reverse bit scan: 10 plus 3 per bit examined
// - plain bit test: 3 register, 6 or 12 memory
// - test-and-clear: 6 register, 8 or 13 memory
// - test-and-set timed as test-and-clear
// - test-and-complement: 6 register, 8 or 13 memory, up to 2 data
// - near direct call: 9 plus m, 2 data
// - near indirect call: 9+m register, 12+m memory, 2 or 3 data
// - far direct call: 42 plus m, 9 data
// - far call via gate: 64, 98 or 106+8x plus m, 13+4x data
// - far indirect call: 46+m, 10 data; gates 68, 102, 110+8x
// - short and near direct jump: 7 plus m
// - near indirect jump: 9+m or 14+m, 2 or 4 data
// - far direct jump: 37+m, 5 data; same-level gate 53+m, 9 data
// - far indirect jump: 37+m, 9 data; same-level gate 59+m, 13
// - iterations come from 16 or 32 bit count, decremented each one
`timescale 1ns/1ns
`include "sbd_defines.svh"

module sbd_cost_decoder (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // request from fetch
  input  wire logic                req_valid_i,
  input  wire sbd_pkg::sbd_req_type req_i,
  output logic                     ready_o,
  // string count and bit scan length
  input  wire logic [31:0]         count_i,
  input  wire logic                count_wide_i,
  input  wire logic [5:0]          bits_i,
  // compare outcome of the current iteration
  input  wire logic                match_i,
  // iteration progress
  output logic                     iter_o,
  output logic [31:0]              count_o,
  // result
  output logic                     done_o,
  output sbd_pkg::sbd_res_type     res_o
);

  typedef enum logic [1:0] {SBD_IDLE, SBD_RUN, SBD_REPORT} sbd_state_type;

  sbd_state_type        state;
  sbd_pkg::sbd_cost_type cost;
  sbd_pkg::sbd_cost_type next_cost;
  logic [31:0]          cnt;
  logic [31:0]          next_cnt;
  logic                 accept;
  logic                 stop;
  logic [31:0]          base_clk;
  logic [31:0]          base_dat;

  // build one cost entry
  function automatic sbd_pkg::sbd_cost_type mk(input sbd_pkg::sbd_group_type g,
                                               input logic [7:0] bc,
                                               input logic [3:0] pc,
                                               input logic [7:0] bd,
                                               input logic [3:0] pd);
    sbd_pkg::sbd_cost_type c;
    c      = '0;
    c.ok   = 1'b1;
    c.grp  = g;
    c.bclk = bc;
    c.pclk = pc;
    c.bdat = bd;
    c.pdat = pd;
    return c;
  endfunction

  // string opcodes behind a repeat prefix
  function automatic sbd_pkg::sbd_cost_type dec_str(input sbd_pkg::sbd_req_type r);
    sbd_pkg::sbd_cost_type c;
    logic                  ne;
    c  = '0;
    ne = (r.lead == `SBD_PFX_REPNE);
    case (r.op[7:1])
      `SBD_OP_CMPS: if (ne) c = mk(sbd_pkg::SBD_GRP_STRING, `SBD_T_5, 4'h9, 8'h00, 4'h2);
      `SBD_OP_INS:  if (!ne) c = mk(sbd_pkg::SBD_GRP_STRING, r.slow ? `SBD_T_27 : `SBD_T_7,
                                    4'h6, 8'h00, 4'h1);
      `SBD_OP_LODS: if (!ne) c = mk(sbd_pkg::SBD_GRP_STRING, `SBD_T_5, 4'h6, 8'h00, 4'h1);
      `SBD_OP_MOVS: if (!ne) c = mk(sbd_pkg::SBD_GRP_STRING, `SBD_T_7, 4'h4, 8'h00, 4'h2);
      `SBD_OP_OUTS: if (!ne) c = mk(sbd_pkg::SBD_GRP_STRING, r.slow ? `SBD_T_26 : `SBD_T_6,
                                    4'h5, 8'h00, 4'h1);
      `SBD_OP_SCAS: c = mk(sbd_pkg::SBD_GRP_STRING, `SBD_T_5, 4'h8, 8'h00, 4'h1);
      `SBD_OP_STOS: if (!ne) c = mk(sbd_pkg::SBD_GRP_STRING, `SBD_T_5, 4'h5, 8'h00, 4'h1);
      default:      c = '0;
    endcase
    // compare and scan may end early on the compare outcome
    c.rep     = c.ok;
    c.scan    = c.ok && (r.op[7:1] == `SBD_OP_CMPS || r.op[7:1] == `SBD_OP_SCAS);
    c.halt_eq = ne;
    return c;
  endfunction

  // bit opcodes behind the escape byte
  function automatic sbd_pkg::sbd_cost_type dec_bit(input sbd_pkg::sbd_req_type r);
    sbd_pkg::sbd_cost_type c;
    c = '0;
    case (r.op)
      `SBD_OP_FSCAN, `SBD_OP_RSCAN: begin
        c      = mk(sbd_pkg::SBD_GRP_BIT, `SBD_T_10, 4'h3, 8'h00, 4'h2);
        c.bits = 1'b1;
      end
      `SBD_OP_TST_R: c = mk(sbd_pkg::SBD_GRP_BIT, r.mem ? `SBD_T_12 : `SBD_T_3,
                           4'h0, {7'h00, r.mem}, 4'h0);
      `SBD_OP_CLR_R, `SBD_OP_SET_R, `SBD_OP_CPL_R:
        c = mk(sbd_pkg::SBD_GRP_BIT, r.mem ? `SBD_T_13 : `SBD_T_6,
               4'h0, r.mem ? 8'h02 : 8'h00, 4'h0);
      `SBD_OP_TGRP: begin
        if (r.fld == `SBD_FLD_TST)
          c = mk(sbd_pkg::SBD_GRP_BIT, r.mem ? `SBD_T_6 : `SBD_T_3,
                 4'h0, {7'h00, r.mem}, 4'h0);
        else if (r.fld == `SBD_FLD_CLR || r.fld == `SBD_FLD_SET || r.fld == `SBD_FLD_CPL)
          c = mk(sbd_pkg::SBD_GRP_BIT, r.mem ? `SBD_T_8 : `SBD_T_6,
                 4'h0, r.mem ? 8'h02 : 8'h00, 4'h0);
      end
      default: c = '0;
    endcase
    return c;
  endfunction

  // far transfer entry, gate kind picks the figures
  function automatic sbd_pkg::sbd_cost_type far(input sbd_pkg::sbd_req_type r,
                                                input logic [7:0] t0, input logic [7:0] d0,
                                                input logic [7:0] t1, input logic [7:0] d1,
                                                input logic [7:0] t2, input logic [7:0] t3,
                                                input logic       dif);
    sbd_pkg::sbd_cost_type c;
    c = '0;
    unique case (r.gate)
      sbd_pkg::SBD_GATE_NONE: c = mk(sbd_pkg::SBD_GRP_XFER, t0, 4'h0, d0, 4'h0);
      sbd_pkg::SBD_GATE_SAME: c = mk(sbd_pkg::SBD_GRP_XFER, t1, 4'h0, d1, 4'h0);
      default: begin
        // different level exists for calls only; zero parameters is its own figure
        if (dif) begin
          c       = mk(sbd_pkg::SBD_GRP_XFER, (r.parm == 5'h00) ? t2 : t3, 4'h0, d1, 4'h0);
          c.per_x = 1'b1;
        end
      end
    endcase
    c.add_m = c.ok;
    return c;
  endfunction

  // transfers, keyed on the first byte
  function automatic sbd_pkg::sbd_cost_type dec_xfer(input sbd_pkg::sbd_req_type r);
    sbd_pkg::sbd_cost_type c;
    c = '0;
    case (r.lead)
      `SBD_OP_CALLN: c = mk(sbd_pkg::SBD_GRP_XFER, `SBD_T_9, 4'h0, 8'h02, 4'h0);
      `SBD_OP_CALLF: c = far(r, `SBD_T_42, 8'h09, `SBD_T_64, 8'h0D,
                             `SBD_T_98, `SBD_T_106, 1'b1);
      `SBD_OP_JMPS, `SBD_OP_JMPN:
        c = mk(sbd_pkg::SBD_GRP_XFER, `SBD_T_7, 4'h0, 8'h00, 4'h0);
      `SBD_OP_JMPF: c = far(r, `SBD_T_37, 8'h05, `SBD_T_53, 8'h09,
                            8'h00, 8'h00, 1'b0);
      `SBD_OP_GRP5: begin
        case (r.fld)
          `SBD_FLD_CALLN: c = mk(sbd_pkg::SBD_GRP_XFER, r.mem ? `SBD_T_12 : `SBD_T_9,
                                 4'h0, r.mem ? 8'h03 : 8'h02, 4'h0);
          `SBD_FLD_CALLF: c = far(r, `SBD_T_46, 8'h0A, `SBD_T_68, 8'h0E,
                                  `SBD_T_102, `SBD_T_110, 1'b1);
          `SBD_FLD_JMPN:  c = mk(sbd_pkg::SBD_GRP_XFER, r.mem ? `SBD_T_14 : `SBD_T_9,
                                 4'h0, r.mem ? 8'h04 : 8'h02, 4'h0);
          `SBD_FLD_JMPF:  c = far(r, `SBD_T_37, 8'h09, `SBD_T_59, 8'h0D,
                                  8'h00, 8'h00, 1'b0);
          default:        c = '0;
        endcase
      end
      default: c = '0;
    endcase
    c.add_m = c.ok;
    return c;
  endfunction

  // pick the decoder by the lead byte
  always_comb begin
    if (req_i.lead == `SBD_PFX_REP || req_i.lead == `SBD_PFX_REPNE)
      next_cost = dec_str(req_i);
    else if (req_i.lead == `SBD_ESC)
      next_cost = dec_bit(req_i);
    else
      next_cost = dec_xfer(req_i);
  end

  // fixed part of the total: base, m, 8 per gate parameter, 3 per bit examined
  always_comb begin
    base_clk = {24'h000000, next_cost.bclk}
             + (next_cost.add_m ? {24'h000000, req_i.comp} : 32'h00000000)
             + (next_cost.per_x ? 32'({27'h0, req_i.parm} * `SBD_P_PARM_CLK)
                                : 32'h00000000)
             + (next_cost.bits ? 32'({26'h0, bits_i} * next_cost.pclk)
                               : 32'h00000000);
    base_dat = {24'h000000, next_cost.bdat}
             + (next_cost.per_x ? 32'({27'h0, req_i.parm} * `SBD_P_PARM_DAT)
                                : 32'h00000000)
             + (next_cost.bits ? 32'({26'h0, bits_i} * next_cost.pdat)
                               : 32'h00000000);
  end

  // 16-bit form ignores the upper count half
  assign next_cnt = count_wide_i ? count_i : {16'h0000, count_i[15:0]};
  assign accept   = req_valid_i && (state == SBD_IDLE);
  assign ready_o  = (state == SBD_IDLE);
  assign iter_o   = (state == SBD_RUN);
  assign done_o   = (state == SBD_REPORT);
  assign count_o  = cnt;
  // scan and compare end on the iteration whose outcome meets the halt sense
  assign stop     = cost.scan && (match_i == cost.halt_eq);

  // sequencer; an empty count reports the base figure alone
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SBD_IDLE;
    end else begin
      unique case (state)
        SBD_IDLE: if (req_valid_i) begin
          if (next_cost.rep && next_cnt != 32'h00000000)
            state <= SBD_RUN;
          else
            state <= SBD_REPORT;
        end
        SBD_RUN: if (cnt == 32'h00000001 || stop) state <= SBD_REPORT;
        SBD_REPORT: state <= SBD_IDLE;
      endcase
    end
  end

  // latched cost entry and the running count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cost <= '0;
      cnt  <= 32'h00000000;
    end else if (accept) begin
      cost <= next_cost;
      cnt  <= next_cnt;
    end else if (iter_o) begin
      cnt  <= cnt - 32'h00000001;
    end
  end

  // result totals; each iteration adds its per-iteration figures
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_o <= '0;
    end else if (accept) begin
      res_o.ok     <= next_cost.ok;
      res_o.grp    <= next_cost.grp;
      res_o.clocks <= base_clk;
      res_o.data   <= base_dat;
    end else if (iter_o) begin
      res_o.clocks <= res_o.clocks + {28'h0000000, cost.pclk};
      res_o.data   <= res_o.data + {28'h0000000, cost.pdat};
    end
  end

  // checks
  AST_COUNT_DOWN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    iter_o |=> count_o == $past(count_o) - 32'h00000001 || done_o)
    else $error("count not decremented per iteration");

  AST_MOVS_STEP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    iter_o && cost.rep && cost.pclk == 4'h4 |=>
      res_o.clocks == $past(res_o.clocks) + 32'h00000004
      && res_o.data == $past(res_o.data) + 32'h00000002)
    else $error("move iteration cost wrong");

  AST_CMPS_BASE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'hF2 && req_i.op[7:1] == 7'h53 |=>
      res_o.clocks == 32'h00000005 && res_o.ok)
    else $error("repne compare base wrong");

  AST_SCAN_HALT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    iter_o && cost.scan && match_i == cost.halt_eq |=> done_o ##1 ready_o)
    else $error("scan did not stop on its outcome");

  AST_BITSCAN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'h0F && req_i.op == 8'hBC |=>
      done_o && res_o.clocks == 32'h0000000A + 32'h3 * $past(bits_i))
    else $error("bit scan total wrong");

  AST_BT_REG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'h0F && req_i.op == 8'hA3 |=>
      res_o.clocks == ($past(req_i.mem) ? 32'h0000000C : 32'h00000003))
    else $error("bit test total wrong");

  AST_FARCALL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'h9A && req_i.gate == sbd_pkg::SBD_GATE_NONE |=>
      res_o.clocks == 32'h2A + $past(req_i.comp) && res_o.data == 32'h9)
    else $error("far call total wrong");

  AST_GATE_PARM: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'h9A && req_i.gate == sbd_pkg::SBD_GATE_DIFF
      && req_i.parm != 5'h00 |=>
      res_o.clocks == 32'h6A + 32'h8 * $past(req_i.parm) + $past(req_i.comp)
      && res_o.data == 32'hD + 32'h4 * $past(req_i.parm))
    else $error("gate call with parameters wrong");

  AST_SHORT_JMP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == 8'hEB |=>
      done_o && res_o.clocks == 32'h7 + $past(req_i.comp))
    else $error("short jump total wrong");

  // an empty count must not enter the iteration loop
  AST_ZERO_CNT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && next_cost.rep && next_cnt == 32'h00000000 |=> done_o && !iter_o)
    else $error("empty count ran an iteration");

  // result strobe lasts one cycle and frees the decoder
  AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    done_o |=> !done_o && ready_o)
    else $error("result strobe not a single cycle");

  AST_INS_BASE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == `SBD_PFX_REP && req_i.op[7:1] == `SBD_OP_INS |=>
      res_o.clocks == ($past(req_i.slow) ? 32'd27 : 32'd7) && res_o.data == 32'h0)
    else $error("port input base wrong");

  AST_OUTS_BASE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == `SBD_PFX_REP && req_i.op[7:1] == `SBD_OP_OUTS |=>
      res_o.clocks == ($past(req_i.slow) ? 32'd26 : 32'd6) && res_o.data == 32'h0)
    else $error("port output base wrong");

  AST_NEAR_CALL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == `SBD_OP_CALLN |=>
      res_o.clocks == 32'd9 + $past(req_i.comp) && res_o.data == 32'h2)
    else $error("near call total wrong");

  AST_FAR_JMP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == `SBD_OP_JMPF && req_i.gate == sbd_pkg::SBD_GATE_NONE |=>
      res_o.clocks == 32'd37 + $past(req_i.comp) && res_o.data == 32'h5)
    else $error("far jump total wrong");

  AST_CPL_IMM: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && req_i.lead == `SBD_ESC && req_i.op == `SBD_OP_TGRP
      && req_i.fld == `SBD_FLD_CPL |=>
      res_o.clocks == ($past(req_i.mem) ? 32'd8 : 32'd6))
    else $error("complement immediate total wrong");

endmodule // sbd_cost_decoder

// ==== verification/sbd_fetch_model.sv ====
// Purpose: far-side model that answers the compare outcome of each iteration
// Assumes: one core clock; iterations are flagged by the decoder
// Notes:   outside iterations the compare line toggles so a stale value is never trusted
`timescale 1ns/1ns
module sbd_fetch_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // decoder progress
  input  wire logic       iter_i,
  input  wire logic       done_i,
  // scenario control
  input  wire logic [7:0] halt_at_i,
  input  wire logic       sense_i,
  // compare outcome
  output logic            match_o
);
  logic [7:0] idx;

  // iterations already performed in the current operation
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) idx <= 8'h00;
    else if (done_i) idx <= 8'h00;
    else if (iter_i) idx <= idx + 8'h01;
  end

  // outcome settles just after the edge, as a real compare path would
  initial match_o = 1'b0;
  always @(posedge clk_i) begin
    #1;
    if (iter_i) match_o = (idx + 8'h01 == halt_at_i) ? sense_i : !sense_i;
    else match_o = !match_o;
  end
endmodule // sbd_fetch_model

// ==== verification/sbd_cost_decoder_tb.sv ====
// Purpose: self-checking bench for the string, bit and transfer cost decoder
// Assumes: requests are driven 1 ns after the rising edge
// Notes:   expectations come from the bench's own cost table, never from the design
`timescale 1ns/1ns
`include "sbd_defines.svh"
`define SBD_CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %0h want %0h", $time, act, exp); end end
module sbd_cost_decoder_tb;
  logic                 clk_i;
  logic                 arst_n_i;
  logic                 req_valid_i;
  sbd_pkg::sbd_req_type req_i;
  logic                 ready_o;
  logic [31:0]          count_i;
  logic                 count_wide_i;
  logic [5:0]           bits_i;
  logic                 match_i;
  logic                 iter_o;
  logic [31:0]          count_o;
  logic                 done_o;
  sbd_pkg::sbd_res_type res_o;
  logic [7:0]           halt_at;
  logic                 sense;
  int                   n_fail;
  int                   cmp_count;
  logic [31:0]          seed;
  logic [19:0]          enc [32];

  sbd_cost_decoder i_sbd_cost_decoder (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o), .count_i(count_i),
    .count_wide_i(count_wide_i), .bits_i(bits_i), .match_i(match_i), .iter_o(iter_o),
    .count_o(count_o), .done_o(done_o), .res_o(res_o));
  sbd_fetch_model i_sbd_fetch_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .iter_i(iter_o),
    .done_i(done_o), .halt_at_i(halt_at), .sense_i(sense), .match_o(match_i));

  // free-running core clock, 10 ns period
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // xorshift keeps the run repeatable from one fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // cost table: ok, group, base clocks, clocks each, base data, data each, halts, sense
  function automatic void calc(input sbd_pkg::sbd_req_type r, input int nb, output int e [8]);
    int m;
    int x;
    int gt;
    int mm;
    int rn;
    logic [6:0] so;
    m = int'(r.comp);
    x = int'(r.parm);
    gt = int'(r.gate);
    mm = int'(r.mem);
    rn = int'(r.lead == `SBD_PFX_REPNE);
    so = r.op[7:1];
    e = '{0, 0, 0, 0, 0, 0, 0, 0};
    if (r.lead == `SBD_PFX_REP || rn == 1) begin
      if (so == `SBD_OP_SCAS) e = '{1, 1, 5, 8, 0, 1, 1, rn};
      else if (rn == 1 && so == `SBD_OP_CMPS) e = '{1, 1, 5, 9, 0, 2, 1, 1};
      else if (rn == 1) e = '{0, 0, 0, 0, 0, 0, 0, 0};
      else if (so == `SBD_OP_INS) e = '{1, 1, r.slow ? 27 : 7, 6, 0, 1, 0, 0};
      else if (so == `SBD_OP_LODS) e = '{1, 1, 5, 6, 0, 1, 0, 0};
      else if (so == `SBD_OP_MOVS) e = '{1, 1, 7, 4, 0, 2, 0, 0};
      else if (so == `SBD_OP_OUTS) e = '{1, 1, r.slow ? 26 : 6, 5, 0, 1, 0, 0};
      else if (so == `SBD_OP_STOS) e = '{1, 1, 5, 5, 0, 1, 0, 0};
    end else if (r.lead == `SBD_ESC) begin
      if (r.op == `SBD_OP_FSCAN || r.op == `SBD_OP_RSCAN)
        e = '{1, 2, 10 + 3 * nb, 0, 2 * nb, 0, 0, 0};
      else if (r.op == `SBD_OP_TST_R) e = '{1, 2, r.mem ? 12 : 3, 0, mm, 0, 0, 0};
      else if (r.op == `SBD_OP_CLR_R || r.op == `SBD_OP_SET_R || r.op == `SBD_OP_CPL_R)
        e = '{1, 2, r.mem ? 13 : 6, 0, 2 * mm, 0, 0, 0};
      else if (r.op == `SBD_OP_TGRP && r.fld == `SBD_FLD_TST)
        e = '{1, 2, r.mem ? 6 : 3, 0, mm, 0, 0, 0};
      else if (r.op == `SBD_OP_TGRP && r.fld >= `SBD_FLD_SET)
        e = '{1, 2, r.mem ? 8 : 6, 0, 2 * mm, 0, 0, 0};
    end else if (r.lead == `SBD_OP_CALLN) e = '{1, 3, 9 + m, 0, 2, 0, 0, 0};
    else if (r.lead == `SBD_OP_JMPS || r.lead == `SBD_OP_JMPN)
      e = '{1, 3, 7 + m, 0, 0, 0, 0, 0};
    else if (r.lead == `SBD_OP_CALLF)
      e = '{1, 3, (gt == 0) ? 42 + m : (gt == 1) ? 64 + m : (x == 0) ? 98 + m :
            106 + 8 * x + m, 0, (gt == 0) ? 9 : (gt == 1) ? 13 : 13 + 4 * x, 0, 0, 0};
    else if (r.lead == `SBD_OP_JMPF && gt < 2)
      e = '{1, 3, (gt == 0) ? 37 + m : 53 + m, 0, (gt == 0) ? 5 : 9, 0, 0, 0};
    else if (r.lead == `SBD_OP_GRP5) begin
      if (r.fld == `SBD_FLD_CALLN) e = '{1, 3, r.mem ? 12 + m : 9 + m, 0, 2 + mm, 0, 0, 0};
      else if (r.fld == `SBD_FLD_CALLF)
        e = '{1, 3, (gt == 0) ? 46 + m : (gt == 1) ? 68 + m : (x == 0) ? 102 + m :
              110 + 8 * x + m, 0, (gt == 0) ? 10 : (gt == 1) ? 14 : 14 + 4 * x, 0, 0, 0};
      else if (r.fld == `SBD_FLD_JMPN)
        e = '{1, 3, r.mem ? 14 + m : 9 + m, 0, 2 + 2 * mm, 0, 0, 0};
      else if (r.fld == `SBD_FLD_JMPF && gt < 2)
        e = '{1, 3, (gt == 0) ? 37 + m : 59 + m, 0, (gt == 0) ? 9 : 13, 0, 0, 0};
    end
  endfunction

  // one operation; pest keeps a junk request up while busy, which must be ignored
  task automatic run(input sbd_pkg::sbd_req_type r, input logic [31:0] cnt, input logic wide,
      input logic [5:0] nb, input int halt, input bit pest);
    int e [8];
    int n;
    int k;
    int its;
    int cyc;
    calc(r, int'(nb), e);
    n = (e[0] == 1 && e[1] == 1) ? int'(wide ? cnt : {16'h0000, cnt[15:0]}) : 0;
    k = (e[6] == 1 && halt >= 1 && halt <= n) ? halt : n;
    its = 0;
    cyc = 0;
    halt_at = 8'(halt);
    sense = e[7][0];
    req_i = r;
    count_i = cnt;
    count_wide_i = wide;
    bits_i = nb;
    req_valid_i = 1'b1;
    while (ready_o !== 1'b1 && cyc < 50) begin
      @(posedge clk_i);
      #1;
      cyc++;
    end
    if (ready_o !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clk_i);
    #1;
    req_valid_i = pest && done_o !== 1'b1;
    req_i = sbd_pkg::sbd_req_type'(36'({rnd(), rnd()}));
    cyc = 1;
    while (done_o !== 1'b1 && cyc < 300) begin
      if (iter_o === 1'b1) begin
        `SBD_CHK(count_o, 32'(n - its))
        its++;
      end
      @(posedge clk_i);
      #1;
      cyc++;
    end
    if (cyc > 1) req_valid_i = 1'b0;
    if (done_o !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    `SBD_CHK(cyc, k + 1)
    `SBD_CHK(its, k)
    `SBD_CHK(res_o.ok, e[0][0])
    `SBD_CHK(res_o.grp, sbd_pkg::sbd_group_type'(e[1][1:0]))
    `SBD_CHK(res_o.clocks, 32'(e[2] + e[3] * k))
    `SBD_CHK(res_o.data, 32'(e[4] + e[5] * k))
    if (n > 0) `SBD_CHK(count_o, 32'(n - k))
    @(posedge clk_i);
    #1;
  endtask

  // main sequence: every encoding per pass, corners on passes 0 and 1, refusals included
  initial begin
    sbd_pkg::sbd_req_type r;
    logic [19:0] t;
    logic [31:0] v;
    logic [31:0] w;
    logic [31:0] cnt;
    n_fail = 0;
    cmp_count = 0;
    seed = 32'hFC431C37;
    enc = '{20'hF2A60, 20'hF36C0, 20'hF3AC0, 20'hF3A40, 20'hF36E0, 20'hF3AE0, 20'hF2AE0,
            20'hF3AA0, 20'hF3A60, 20'hF2A40, 20'h0FBC0, 20'h0FBD0, 20'h0FBA4, 20'h0FBA5,
            20'h0FBA6, 20'h0FBA7, 20'h0FBA0, 20'h0FA30, 20'h0FB30, 20'h0FAB0, 20'h0FBB0,
            20'hE8000, 20'h9A000, 20'hFF002, 20'hFF003, 20'hFF004, 20'hFF005, 20'hFF000,
            20'hEB000, 20'hE9000, 20'hEA000, 20'h00000};
    arst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    count_i = 32'h0;
    count_wide_i = 1'b0;
    bits_i = 6'h00;
    halt_at = 8'h00;
    sense = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    for (int pass = 0; pass < 4; pass++) begin
      for (int i = 0; i < 32; i++) begin
        t = enc[i];
        v = rnd();
        w = rnd();
        r = sbd_pkg::sbd_req_type'(36'({rnd(), rnd()}));
        r.lead = t[19:12];
        r.op = t[11:4] | ((t[19:13] == 7'h79) ? {7'h00, v[2]} : 8'h00);
        r.fld = t[2:0];
        r.gate = (t[19:12] == 8'h9A || t[19:12] == 8'hEA || (t[19:12] == 8'hFF && t[0])) ?
                 sbd_pkg::sbd_gate_type'(2'(w % 3)) : sbd_pkg::SBD_GATE_NONE;
        r.parm = (pass == 0) ? 5'h00 : r.parm;
        r.comp = (pass == 1) ? 8'hFF : r.comp;
        cnt = (pass == 0) ? 32'h0 : 32'(w[31:8] % 7);
        if (!v[0]) cnt[31:16] = w[31:16];
        run(r, cnt, v[0], (pass == 1) ? 6'h3F : w[13:8], int'(v[7:4] % 8), v[1]);
      end
    end
    tally_and_finish();
  end
endmodule // sbd_cost_decoder_tb
